/* design/mrtu_link_if.sv */
// Byte-stream link between the master and the slave message handler.
`timescale 1ns/1ns
`default_nettype none
interface mrtu_link_if;
    logic       m2s_valid;
    logic [7:0] m2s_data;
    logic       m2s_last;
    logic       s2m_valid;
    logic [7:0] s2m_data;
    logic       s2m_last;

    modport slave_mp (input m2s_valid, m2s_data, m2s_last,
                      output s2m_valid, s2m_data, s2m_last);
    modport master_mp (output m2s_valid, m2s_data, m2s_last,
                       input s2m_valid, s2m_data, s2m_last);
endinterface : mrtu_link_if
`default_nettype wire

/* design/mrtu_master.sv */
// Master end: builds command frames and checks the CRC of each response.
`timescale 1ns/1ns
`default_nettype none
module mrtu_master (
    // Clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_sys_rst,
    // Link to the slave
    mrtu_link_if.master_mp    link,
    // Request
    input  wire logic         i_req_valid,
    input  wire logic [7:0]   i_req_slave,
    input  wire logic [7:0]   i_req_func,
    input  wire logic [15:0]  i_req_word0,
    input  wire logic [15:0]  i_req_word1,
    input  wire logic [255:0] i_req_data,
    output logic              o_req_ready,
    // Response
    output logic              o_rsp_valid,
    output logic              o_rsp_ok,
    output logic              o_rsp_timeout,
    output logic [5:0]        o_rsp_len,
    output logic [7:0]        o_rsp_func,
    output logic [7:0]        o_rsp_code,
    output logic [255:0]      o_rsp_words
);

    mrtu_pkg::mrtu_mst_state_type st_q, st_d;
    logic [7:0]   slv_q, slv_d, fc_q, fc_d;
    logic [15:0]  w0_q, w0_d, w1_q, w1_d, crc_q, crc_d;
    logic [255:0] dat_q, dat_d, words;
    logic [5:0]   idx_q, idx_d, plen_q, plen_d, rcnt_q, rcnt_d;
    logic [7:0]   tmo_q, tmo_d;
    logic [7:0]   rx_q [0:mrtu_pkg::FRAME_MAX-1];
    logic [7:0]   rx_d [0:mrtu_pkg::FRAME_MAX-1];
    logic [7:0]   tx_byte;
    logic [3:0]   wk;
    logic [15:0]  dw;
    logic         rsp_v_d, rsp_to_d, rsp_ok_d;

    // ------------------------------------------------------------
    // Command byte generator
    // ------------------------------------------------------------
    assign wk = 4'((idx_q - mrtu_pkg::WRN_HDR) >> 1);
    assign dw = dat_q[{wk, 4'h0} +: 16];

    always_comb begin
        if (idx_q == plen_q) begin
            tx_byte = crc_q[7:0];
        end else if (idx_q > plen_q) begin
            tx_byte = crc_q[15:8];
        end else begin
            unique case (idx_q)
                6'd0:    tx_byte = slv_q;
                6'd1:    tx_byte = fc_q;
                6'd2:    tx_byte = w0_q[15:8];
                6'd3:    tx_byte = w0_q[7:0];
                6'd4:    tx_byte = w1_q[15:8];
                6'd5:    tx_byte = w1_q[7:0];
                6'd6:    tx_byte = {w1_q[6:0], 1'b0};
                default: tx_byte = idx_q[0] ? dw[15:8] : dw[7:0];
            endcase
        end
    end

    assign link.m2s_valid = (st_q == mrtu_pkg::MS_TX);
    assign link.m2s_data  = tx_byte;
    assign link.m2s_last  = (st_q == mrtu_pkg::MS_TX) && (idx_q == plen_q + 6'd1);
    assign o_req_ready    = (st_q == mrtu_pkg::MS_IDLE);
    assign rsp_v_d        = (st_q == mrtu_pkg::MS_DONE);
    assign rsp_to_d       = rsp_v_d && !link.s2m_valid && (tmo_q != 8'h00);
    assign rsp_ok_d       = (crc_q == 16'h0000) && (rcnt_q >= mrtu_pkg::RSP_MIN)
                            && (tmo_q == 8'h00);

    always_comb begin
        for (int k = 0; k < 16; k++) begin
            words[k*16 +: 16] = {rx_q[3 + 2*k], rx_q[4 + 2*k]};
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d   = st_q;
        slv_d  = slv_q;
        fc_d   = fc_q;
        w0_d   = w0_q;
        w1_d   = w1_q;
        dat_d  = dat_q;
        idx_d  = idx_q;
        plen_d = plen_q;
        rcnt_d = rcnt_q;
        tmo_d  = tmo_q;
        crc_d  = crc_q;
        rx_d   = rx_q;
        unique case (st_q)
            mrtu_pkg::MS_IDLE: begin
                if (i_req_valid) begin
                    // Loopback test code and data ride in word0 and word1.
                    slv_d  = i_req_slave;
                    fc_d   = i_req_func;
                    w0_d   = i_req_word0;
                    w1_d   = i_req_word1;
                    dat_d  = i_req_data;
                    idx_d  = 6'd0;
                    crc_d  = mrtu_pkg::CRC_INIT;
                    plen_d = (i_req_func == mrtu_pkg::FC_WRN)
                             ? mrtu_pkg::WRN_HDR + {i_req_word1[4:0], 1'b0}
                             : mrtu_pkg::ECHO_PLEN;
                    st_d   = mrtu_pkg::MS_TX;
                end
            end
            mrtu_pkg::MS_TX: begin
                if (idx_q < plen_q) begin
                    crc_d = mrtu_pkg::crc_step(crc_q, tx_byte);
                end
                idx_d = idx_q + 6'd1;
                if (idx_q == plen_q + 6'd1) begin
                    crc_d  = mrtu_pkg::CRC_INIT;
                    rcnt_d = 6'd0;
                    tmo_d  = 8'h00;
                    st_d   = (slv_q == mrtu_pkg::BCAST_ADDR)
                             ? mrtu_pkg::MS_IDLE : mrtu_pkg::MS_WAIT;
                end
            end
            mrtu_pkg::MS_WAIT: begin
                tmo_d = tmo_q + 8'h01;
                if (link.s2m_valid) begin
                    tmo_d = 8'h00;
                    if (rcnt_q < 6'(mrtu_pkg::FRAME_MAX)) begin
                        rx_d[rcnt_q] = link.s2m_data;
                    end
                    if (rcnt_q != 6'h3f) begin
                        rcnt_d = rcnt_q + 6'd1;
                    end
                    crc_d = mrtu_pkg::crc_step(crc_q, link.s2m_data);
                    if (link.s2m_last) begin
                        st_d = mrtu_pkg::MS_DONE;
                    end
                end else if (tmo_q == mrtu_pkg::RSP_WAIT) begin
                    st_d = mrtu_pkg::MS_DONE;
                end
            end
            mrtu_pkg::MS_DONE: begin
                st_d = mrtu_pkg::MS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_q          <= mrtu_pkg::MS_IDLE;
            slv_q         <= 8'h00;
            fc_q          <= 8'h00;
            w0_q          <= 16'h0000;
            w1_q          <= 16'h0000;
            dat_q         <= 256'h0;
            idx_q         <= 6'd0;
            plen_q        <= 6'd0;
            rcnt_q        <= 6'd0;
            tmo_q         <= 8'h00;
            crc_q         <= mrtu_pkg::CRC_INIT;
            o_rsp_valid   <= 1'b0;
            o_rsp_ok      <= 1'b0;
            o_rsp_timeout <= 1'b0;
            o_rsp_len     <= 6'd0;
            o_rsp_func    <= 8'h00;
            o_rsp_code    <= 8'h00;
            o_rsp_words   <= 256'h0;
            for (int i = 0; i < mrtu_pkg::FRAME_MAX; i++) begin
                rx_q[i] <= 8'h00;
            end
        end else begin
            st_q          <= st_d;
            slv_q         <= slv_d;
            fc_q          <= fc_d;
            w0_q          <= w0_d;
            w1_q          <= w1_d;
            dat_q         <= dat_d;
            idx_q         <= idx_d;
            plen_q        <= plen_d;
            rcnt_q        <= rcnt_d;
            tmo_q         <= tmo_d;
            crc_q         <= crc_d;
            rx_q          <= rx_d;
            o_rsp_valid   <= rsp_v_d;
            o_rsp_timeout <= rsp_to_d;
            o_rsp_ok      <= rsp_ok_d;
            o_rsp_len     <= rcnt_q;
            o_rsp_func    <= rx_q[1];
            o_rsp_code    <= rx_q[2];
            o_rsp_words   <= words;
        end
    end

endmodule : mrtu_master
`default_nettype wire

/* design/mrtu_pkg.sv */
// Shared constants, states and the CRC step for the Modbus RTU message handler.
package mrtu_pkg;

    // ------------------------------------------------------------
    // Frame layout and limits
    // ------------------------------------------------------------
    localparam int          FRAME_MAX  = 41;
    localparam int          NREG       = 32;
    localparam logic [5:0]  FIXED_LEN  = 6'd8;
    localparam logic [5:0]  MIN_LEN    = 6'd4;
    localparam logic [5:0]  RSP_MIN    = 6'd5;
    localparam logic [5:0]  ECHO_PLEN  = 6'd6;
    localparam logic [5:0]  ERR_PLEN   = 6'd3;
    localparam logic [5:0]  READ_HDR   = 6'd3;
    localparam logic [5:0]  WRN_HDR    = 6'd7;
    localparam logic [8:0]  WRN_OVH    = 9'd9;
    localparam logic [15:0] MAX_WORDS  = 16'h0010;
    localparam logic [16:0] NREG_LIM   = 17'h00020;
    localparam logic [7:0]  BCAST_ADDR = 8'h00;
    localparam logic [7:0]  RSP_WAIT   = 8'h40;

    // ------------------------------------------------------------
    // Function and error codes
    // ------------------------------------------------------------
    localparam logic [7:0]  FC_READ    = 8'h03;
    localparam logic [7:0]  FC_WR1     = 8'h06;
    localparam logic [7:0]  FC_LOOP    = 8'h08;
    localparam logic [7:0]  FC_WRN     = 8'h10;
    localparam logic [7:0]  FC_ERR_BIT = 8'h80;
    localparam logic [7:0]  ERR_FUNC   = 8'h01;
    localparam logic [7:0]  ERR_ADDR   = 8'h02;
    localparam logic [7:0]  ERR_VALUE  = 8'h03;

    // ------------------------------------------------------------
    // CRC-16
    // ------------------------------------------------------------
    localparam logic [15:0] CRC_INIT   = 16'hffff;
    localparam logic [15:0] CRC_POLY   = 16'ha001;

    typedef enum logic [1:0] {SL_RX, SL_EXEC, SL_STORE, SL_TX} mrtu_slv_state_type;
    typedef enum logic [1:0] {MS_IDLE, MS_TX, MS_WAIT, MS_DONE} mrtu_mst_state_type;

    // Bit-serial, LSB first: the accumulator low byte is the first CRC byte on the wire.
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_step

endpackage : mrtu_pkg

/* design/mrtu_slave.sv */
// Slave end: frame check, function execution and response building.
`timescale 1ns/1ns
`default_nettype none
module mrtu_slave (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    // Link to the master
    mrtu_link_if.slave_mp    link,
    // Node address
    input  wire logic [7:0]  i_node_addr,
    // Register store notification
    output logic             o_wr_stb,
    output logic [15:0]      o_wr_addr,
    output logic [15:0]      o_wr_data,
    // Frame discard notification
    output logic             o_drop
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    mrtu_pkg::mrtu_slv_state_type st_q, st_d;
    logic [7:0]  rx_q   [0:mrtu_pkg::FRAME_MAX-1];
    logic [7:0]  rx_d   [0:mrtu_pkg::FRAME_MAX-1];
    logic [15:0] regs_q [0:mrtu_pkg::NREG-1];
    logic [15:0] regs_d [0:mrtu_pkg::NREG-1];
    logic [5:0]  cnt_q, cnt_d;
    logic [5:0]  idx_q, idx_d;
    logic [5:0]  plen_q, plen_d;
    logic [15:0] crc_q, crc_d;
    logic [7:0]  err_q, err_d;
    logic        ovf_q, ovf_d;
    logic        quiet_q, quiet_d;
    logic        wr_stb_d, drop_d;
    logic [15:0] wr_addr_d, wr_data_d;

    logic [15:0] start, num;
    logic        num_ok, rng_ok, frame_ok;
    logic [7:0]  tx_byte;
    logic [4:0]  rd_idx;
    logic [15:0] rd_word;
    logic [5:0]  wk_hi;

    assign start    = {rx_q[2], rx_q[3]};
    assign num      = {rx_q[4], rx_q[5]};
    assign num_ok   = (num != 16'h0000) && (num <= mrtu_pkg::MAX_WORDS);
    assign rng_ok   = ({1'b0, start} + {1'b0, num}) <= mrtu_pkg::NREG_LIM;
    // A residue of zero after the two CRC bytes proves the whole frame.
    assign frame_ok = !ovf_q && (cnt_q >= mrtu_pkg::MIN_LEN) && (crc_q == 16'h0000)
                      && ((rx_q[0] == i_node_addr) || (rx_q[0] == mrtu_pkg::BCAST_ADDR));
    assign wk_hi    = mrtu_pkg::WRN_HDR + {idx_q[4:0], 1'b0};

    // ------------------------------------------------------------
    // Response byte generator
    // ------------------------------------------------------------
    assign rd_idx  = 5'(idx_q - mrtu_pkg::READ_HDR) >> 1;
    assign rd_word = regs_q[5'(start[4:0] + rd_idx)];

    always_comb begin
        if (idx_q == plen_q) begin
            tx_byte = crc_q[7:0];
        end else if (idx_q > plen_q) begin
            tx_byte = crc_q[15:8];
        end else if (err_q != 8'h00) begin
            unique case (idx_q)
                6'd0:    tx_byte = rx_q[0];
                6'd1:    tx_byte = rx_q[1] | mrtu_pkg::FC_ERR_BIT;
                default: tx_byte = err_q;
            endcase
        end else if (rx_q[1] == mrtu_pkg::FC_READ && idx_q >= 6'd2) begin
            if (idx_q == 6'd2) begin
                tx_byte = {num[6:0], 1'b0};
            end else begin
                tx_byte = idx_q[0] ? rd_word[15:8] : rd_word[7:0];
            end
        end else begin
            // Echo for 06H, 08H and the 10H header.
            tx_byte = rx_q[idx_q];
        end
    end

    assign link.s2m_valid = (st_q == mrtu_pkg::SL_TX);
    assign link.s2m_data  = tx_byte;
    assign link.s2m_last  = (st_q == mrtu_pkg::SL_TX) && (idx_q == plen_q + 6'd1);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d      = st_q;
        rx_d      = rx_q;
        regs_d    = regs_q;
        cnt_d     = cnt_q;
        idx_d     = idx_q;
        plen_d    = plen_q;
        crc_d     = crc_q;
        err_d     = err_q;
        ovf_d     = ovf_q;
        quiet_d   = quiet_q;
        wr_stb_d  = 1'b0;
        drop_d    = 1'b0;
        wr_addr_d = o_wr_addr;
        wr_data_d = o_wr_data;
        unique case (st_q)
            mrtu_pkg::SL_RX: begin
                if (link.m2s_valid) begin
                    if (cnt_q < 6'(mrtu_pkg::FRAME_MAX)) begin
                        rx_d[cnt_q] = link.m2s_data;
                    end else begin
                        ovf_d = 1'b1;
                    end
                    if (cnt_q != 6'h3f) begin
                        cnt_d = cnt_q + 6'd1;
                    end
                    crc_d = mrtu_pkg::crc_step(crc_q, link.m2s_data);
                    if (link.m2s_last) begin
                        st_d = mrtu_pkg::SL_EXEC;
                    end
                end
            end
            mrtu_pkg::SL_EXEC: begin
                st_d    = mrtu_pkg::SL_RX;
                cnt_d   = 6'd0;
                ovf_d   = 1'b0;
                idx_d   = 6'd0;
                err_d   = 8'h00;
                crc_d   = mrtu_pkg::CRC_INIT;
                quiet_d = (rx_q[0] == mrtu_pkg::BCAST_ADDR)
                          || (i_node_addr == mrtu_pkg::BCAST_ADDR);
                if (!frame_ok) begin
                    drop_d = 1'b1;
                end else begin
                    plen_d = mrtu_pkg::ECHO_PLEN;
                    case (rx_q[1])
                        mrtu_pkg::FC_READ: begin
                            if (cnt_q != mrtu_pkg::FIXED_LEN || !num_ok) begin
                                err_d = mrtu_pkg::ERR_VALUE;
                            end else if (!rng_ok) begin
                                err_d = mrtu_pkg::ERR_ADDR;
                            end else begin
                                plen_d = mrtu_pkg::READ_HDR + {num[4:0], 1'b0};
                            end
                        end
                        mrtu_pkg::FC_WR1: begin
                            if (cnt_q != mrtu_pkg::FIXED_LEN) begin
                                err_d = mrtu_pkg::ERR_VALUE;
                            end else if (start >= 16'(mrtu_pkg::NREG)) begin
                                err_d = mrtu_pkg::ERR_ADDR;
                            end else begin
                                regs_d[start[4:0]] = num;
                                wr_stb_d  = 1'b1;
                                wr_addr_d = start;
                                wr_data_d = num;
                            end
                        end
                        mrtu_pkg::FC_LOOP: begin
                            if (cnt_q != mrtu_pkg::FIXED_LEN) begin
                                err_d = mrtu_pkg::ERR_VALUE;
                            end
                        end
                        mrtu_pkg::FC_WRN: begin
                            if ({3'b000, cnt_q} != mrtu_pkg::WRN_OVH + {1'b0, rx_q[6]}
                                || rx_q[6] != {num[6:0], 1'b0} || !num_ok) begin
                                err_d = mrtu_pkg::ERR_VALUE;
                            end else if (!rng_ok) begin
                                err_d = mrtu_pkg::ERR_ADDR;
                            end else begin
                                st_d = mrtu_pkg::SL_STORE;
                            end
                        end
                        default: err_d = mrtu_pkg::ERR_FUNC;
                    endcase
                    if (err_d != 8'h00) begin
                        plen_d = mrtu_pkg::ERR_PLEN;
                    end
                    if (st_d != mrtu_pkg::SL_STORE && !quiet_d) begin
                        st_d = mrtu_pkg::SL_TX;
                    end
                end
            end
            mrtu_pkg::SL_STORE: begin
                // One word per cycle keeps the write port single.
                wr_addr_d = start + {11'h000, idx_q[4:0]};
                wr_data_d = {rx_q[wk_hi], rx_q[wk_hi + 6'd1]};
                regs_d[wr_addr_d[4:0]] = wr_data_d;
                wr_stb_d  = 1'b1;
                idx_d     = idx_q + 6'd1;
                if ({10'h000, idx_d} == num) begin
                    idx_d = 6'd0;
                    st_d  = quiet_q ? mrtu_pkg::SL_RX : mrtu_pkg::SL_TX;
                end
            end
            mrtu_pkg::SL_TX: begin
                if (idx_q < plen_q) begin
                    crc_d = mrtu_pkg::crc_step(crc_q, tx_byte);
                end
                idx_d = idx_q + 6'd1;
                if (idx_q == plen_q + 6'd1) begin
                    idx_d = 6'd0;
                    crc_d = mrtu_pkg::CRC_INIT;
                    st_d  = mrtu_pkg::SL_RX;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_q      <= mrtu_pkg::SL_RX;
            cnt_q     <= 6'd0;
            idx_q     <= 6'd0;
            plen_q    <= 6'd0;
            crc_q     <= mrtu_pkg::CRC_INIT;
            err_q     <= 8'h00;
            ovf_q     <= 1'b0;
            quiet_q   <= 1'b0;
            o_wr_stb  <= 1'b0;
            o_wr_addr <= 16'h0000;
            o_wr_data <= 16'h0000;
            o_drop    <= 1'b0;
            for (int i = 0; i < mrtu_pkg::FRAME_MAX; i++) begin
                rx_q[i] <= 8'h00;
            end
            for (int i = 0; i < mrtu_pkg::NREG; i++) begin
                regs_q[i] <= 16'h0000;
            end
        end else begin
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            idx_q     <= idx_d;
            plen_q    <= plen_d;
            crc_q     <= crc_d;
            err_q     <= err_d;
            ovf_q     <= ovf_d;
            quiet_q   <= quiet_d;
            o_wr_stb  <= wr_stb_d;
            o_wr_addr <= wr_addr_d;
            o_wr_data <= wr_data_d;
            o_drop    <= drop_d;
            rx_q      <= rx_d;
            regs_q    <= regs_d;
        end
    end

endmodule : mrtu_slave
`default_nettype wire

/* verif/modbus_rtu_slave_message_handler_tb.sv */
// Self-checking bench: master and slave ends joined across the link.
`timescale 1ns/1ns
`default_nettype none
module modbus_rtu_slave_message_handler_tb;
    logic i_ref_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic req_v = 1'b0;
    logic [7:0] req_s = 8'h00;
    logic [7:0] req_f = 8'h00;
    logic [15:0] w0 = 16'h0000;
    logic [15:0] w1 = 16'h0000;
    logic [255:0] dat = '0;
    logic [255:0] msk;
    logic rdy, rv, rok, rto;
    logic [5:0] rlen;
    logic [7:0] rfn, rcd;
    logic [255:0] rw;
    int error_cnt = 0;
    int tests_run = 0;
    int seed = 32'h3eb4;
    int n, a;
    int wexp = 0;
    int wrs = 0;
    int drops = 0;
    logic drp, wst;
    logic [15:0] wad, wdt;
    logic [7:0] node = 8'h01;
    logic [47:0] errs [6] = '{{8'h05, 32'h00000001, 8'h01}, {8'h03, 32'h001f0002, 8'h02},
                              {8'h03, 32'h00000000, 8'h03}, {8'h06, 32'h00281111, 8'h02},
                              {8'h10, 32'h00000000, 8'h03}, {8'h10, 32'h001f0002, 8'h02}};
    always #2 i_ref_clk = ~i_ref_clk;
    mrtu_link_if link ();
    mrtu_slave i_mrtu_slave (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .link(link),
        .i_node_addr(node), .o_wr_stb(wst), .o_wr_addr(wad), .o_wr_data(wdt), .o_drop(drp));
    always @(negedge i_ref_clk) begin
        if (drp === 1'b1) drops++;
        if (wst === 1'b1) wrs++;
    end
    mrtu_master i_mrtu_master (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .link(link),
        .i_req_valid(req_v), .i_req_slave(req_s), .i_req_func(req_f), .i_req_word0(w0),
        .i_req_word1(w1), .i_req_data(dat), .o_req_ready(rdy), .o_rsp_valid(rv), .o_rsp_ok(rok),
        .o_rsp_timeout(rto), .o_rsp_len(rlen), .o_rsp_func(rfn), .o_rsp_code(rcd), .o_rsp_words(rw));
    mrtu_link_chk i_mrtu_link_chk (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .m2s_valid(link.m2s_valid), .m2s_data(link.m2s_data), .m2s_last(link.m2s_last),
        .s2m_valid(link.s2m_valid), .s2m_data(link.s2m_data), .s2m_last(link.s2m_last));
    function automatic logic [5:0] rd_len(input int k);
        return 6'(5 + 2 * k);
    endfunction : rd_len
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [255:0] got, input logic [255:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Waits for the response strobe, or for ready again after a broadcast frame.
    task automatic xfer(input logic [7:0] s, input logic [7:0] f, input logic [31:0] ws);
        int k;
        repeat (3) @(negedge i_ref_clk);
        {req_s, req_f, w0, w1, req_v} = {s, f, ws, 1'b1};
        @(negedge i_ref_clk);
        req_v = 1'b0;
        for (k = 0; k < 300 && rv !== 1'b1 && !(s == 8'h00 && rdy === 1'b1); k++) begin
            @(negedge i_ref_clk);
        end
        if (k == 300) begin
            error_cnt++;
            print_verdict();
        end
    endtask : xfer
    initial begin
        repeat (16) @(negedge i_ref_clk);
        i_sys_rst = 1'b0;
        repeat (4) begin
            xfer(8'h01, 8'h08, $random(seed));
            check({rok, rlen, rfn, rw[15:0]}, {1'b1, 6'h8, 8'h08, w0[7:0], w1[15:8]});
        end
        $display("loopback done");
        repeat (8) begin
            n = 1 + ($unsigned($random(seed)) % 16);
            a = $unsigned($random(seed)) % (33 - n);
            for (int j = 0; j < 8; j++) dat[32*j +: 32] = $random(seed);
            msk = (256'h1 << (16 * n)) - 256'h1;
            xfer(8'h01, 8'h06, {16'(a), dat[15:0]});
            check({rok, rlen, rcd, rw[15:0]}, {1'b1, 6'h08, 8'h00, 8'(a), dat[15:8]});
            xfer(8'h01, 8'h10, {16'(a), 16'(n)});
            wexp += 1 + n;
            check({rok, rlen, rw[31:24], rw[15:0]}, {1'b1, 6'h8, 8'(n), 8'(a), 8'h0});
            check({wad, wdt, 8'(wrs)}, {16'(a+n-1), dat[16*(n-1) +: 16], 8'(wexp)});
            xfer(8'h01, 8'h03, {16'(a), 16'(n)});
            check({rok, rlen, rcd}, {1'b1, rd_len(n), 8'(2 * n)});
            check(rw & msk, dat & msk);
        end
        $display("write and read done");
        foreach (errs[i]) begin
            xfer(8'h01, errs[i][47:40], errs[i][39:8]);
            check({rok, rlen, rfn, rcd}, {1'b1, 6'h05, req_f | 8'h80, errs[i][7:0]});
        end
        $display("error replies done");
        xfer(8'h07, 8'h08, 32'h00001234);
        check({rto, rok, 8'(drops)}, {2'b10, 8'h01});
        node = 8'h00;
        xfer(8'h00, 8'h06, 32'h0005c3a5);
        @(negedge i_ref_clk);
        node = 8'h01;
        xfer(8'h01, 8'h03, 32'h00050001);
        check({rok, rw[15:0]}, {1'b1, 16'hc3a5});
        $display("address handling done");
        print_verdict();
    end
endmodule : modbus_rtu_slave_message_handler_tb
`default_nettype wire

/* verif/mrtu_link_chk.sv */
// Wire-level checker for the command and response byte streams.
`timescale 1ns/1ns
`default_nettype none
module mrtu_link_chk (
    // Clock, reset and link signals
    input wire logic       i_ref_clk,
    input wire logic       i_sys_rst,
    input wire logic       m2s_valid,
    input wire logic [7:0] m2s_data,
    input wire logic       m2s_last,
    input wire logic       s2m_valid,
    input wire logic [7:0] s2m_data,
    input wire logic       s2m_last
);
    logic [5:0] mi_q;
    logic [5:0] si_q;
    logic [7:0] ca_q;
    logic [7:0] cf_q;
    logic [7:0] cn_q;
    logic [7:0] rf_q;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mi_q <= 6'h00;
            si_q <= 6'h00;
        end else begin
            if (m2s_valid) mi_q <= m2s_last ? 6'h00 : mi_q + 6'h01;
            if (s2m_valid) si_q <= s2m_last ? 6'h00 : si_q + 6'h01;
        end
    end
    // Field capture; a frame's own bytes are known before its reply begins.
    always_ff @(posedge i_ref_clk) begin
        if (m2s_valid && mi_q == 6'h00) ca_q <= m2s_data;
        if (m2s_valid && mi_q == 6'h01) cf_q <= m2s_data;
        if (m2s_valid && mi_q == 6'h05) cn_q <= m2s_data;
        if (s2m_valid && si_q == 6'h01) rf_q <= s2m_data;
    end
    a_reply_addr: assert property (s2m_valid && si_q == 6'h00
        |-> s2m_data == ca_q)
        else $error("reply address differs from command");
    a_func_echo: assert property (s2m_valid && si_q == 6'h01 && !s2m_data[7]
        |-> s2m_data == cf_q)
        else $error("reply function differs from command");
    a_err_func: assert property (s2m_valid && si_q == 6'h01 && s2m_data[7]
        |-> s2m_data == (cf_q | 8'h80))
        else $error("error reply function code wrong");
    a_err_five: assert property (s2m_valid && si_q == 6'h01 && s2m_data[7]
        |-> ##3 s2m_valid && s2m_last)
        else $error("error reply not five bytes");
    a_bcast_quiet: assert property (m2s_valid && m2s_last && ca_q == 8'h00
        |-> ##1 !s2m_valid [*8])
        else $error("reply to broadcast frame");
    a_read_count: assert property (s2m_valid && si_q == 6'h02 && rf_q == 8'h03
        |-> s2m_data == {cn_q[6:0], 1'b0})
        else $error("read byte count wrong");
    a_read_len: assert property (s2m_valid && s2m_last && rf_q == 8'h03
        |-> si_q == {cn_q[4:0], 1'b0} + 6'h04)
        else $error("read reply length wrong");
    a_fixed_len: assert property (s2m_valid && s2m_last
        && rf_q inside {8'h06, 8'h08, 8'h10} |-> si_q == 6'h07)
        else $error("fixed reply length wrong");
    c_err: cover property (s2m_valid && si_q == 6'h01 && s2m_data[7]);
    c_read: cover property (s2m_valid && s2m_last && rf_q == 8'h03);
    c_bcast: cover property (m2s_valid && m2s_last && ca_q == 8'h00);
endmodule : mrtu_link_chk
`default_nettype wire
